// ---- src/dmas_pkg.sv ----
package dmas_pkg;
    localparam logic [7:0] ADDR_PORT_ZERO = 8'h00;
    localparam logic [7:0] ADDR_POINTER_ZERO = 8'h01;
    localparam logic [7:0] ADDR_PORT_ONE = 8'h02;
    localparam logic [7:0] ADDR_POINTER_ONE = 8'h03;
    localparam logic [7:0] ADDR_BANK_SELECT = 8'h04;
    localparam logic [7:0] ADDR_WORKING = 8'h05;
    localparam logic [7:0] ADDR_STATUS = 8'h0a;
    localparam logic [7:0] ADDR_RAM_BASE = 8'h40;
    localparam int BIT_CARRY = 0;
    localparam int BIT_HALF = 1;
    localparam int BIT_ZERO = 2;
    localparam int BIT_WRAP = 3;
    localparam int BIT_HALT = 4;
    localparam int BIT_WDOG = 5;
    localparam logic [7:0] STATUS_WRITABLE = 8'h0f;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int BANK_BITS = 6;
    localparam int BANK_COUNT = 15;

    typedef enum logic [4:0] {
        DMAS_OP_ADD = 5'b00000,
        DMAS_OP_ADC = 5'b00001,
        DMAS_OP_SUB = 5'b00010,
        DMAS_OP_SBC = 5'b00011,
        DMAS_OP_DAA = 5'b00100,
        DMAS_OP_AND = 5'b00101,
        DMAS_OP_OR = 5'b00110,
        DMAS_OP_XOR = 5'b00111,
        DMAS_OP_CPL = 5'b01000,
        DMAS_OP_RL = 5'b01001,
        DMAS_OP_RR = 5'b01010,
        DMAS_OP_RLC = 5'b01011,
        DMAS_OP_RRC = 5'b01100,
        DMAS_OP_INC = 5'b01101,
        DMAS_OP_DEC = 5'b01110,
        DMAS_OP_MOV = 5'b01111
    } dmas_op_e;

    typedef enum logic [1:0] {
        DMAS_DST_NONE = 2'b00,
        DMAS_DST_WORK = 2'b01,
        DMAS_DST_MEM = 2'b10
    } dmas_dst_e;

    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic ac;
        logic z;
        logic ov;
        logic wc;
        logic wac;
        logic wz;
        logic wov;
    } dmas_alu_s;
endpackage

// ---- src/dmas_alu.sv ----
`timescale 1ns/1ps
module dmas_alu (
    input wire dmas_pkg::dmas_op_e op_i, // operation
    input wire logic [7:0] a_i, // working register operand
    input wire logic [7:0] b_i, // memory or immediate operand
    input wire logic c_i, // current carry
    input wire logic ac_i, // current half carry
    output dmas_pkg::dmas_alu_s out_o // result and flag updates
);
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] bb;
    logic cin;
    logic c7;
    logic [7:0] adj;
    logic [8:0] daa;

    // subtract is add of the complement, carry means no borrow
    always_comb begin
        bb = b_i;
        cin = 1'b0;
        case (op_i)
            dmas_pkg::DMAS_OP_ADC: cin = c_i;
            dmas_pkg::DMAS_OP_SUB: begin
                bb = ~b_i;
                cin = 1'b1;
            end
            dmas_pkg::DMAS_OP_SBC: begin
                bb = ~b_i;
                cin = c_i;
            end
            dmas_pkg::DMAS_OP_INC: begin
                bb = 8'h00;
                cin = 1'b1;
            end
            dmas_pkg::DMAS_OP_DEC: bb = 8'hff;
            default: ;
        endcase
    end

    assign sum = {1'b0, a_i} + {1'b0, bb} + {8'h00, cin};
    assign low = {1'b0, a_i[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
    assign c7 = a_i[7] ^ bb[7] ^ sum[7];
    assign adj = {((c_i || a_i[7:4] > 4'h9 || (a_i[7:4] == 4'h9 && a_i[3:0] > 4'h9)) ?
        4'h6 : 4'h0), ((ac_i || a_i[3:0] > 4'h9) ? 4'h6 : 4'h0)};
    assign daa = {1'b0, a_i} + {1'b0, adj};

    always_comb begin
        out_o = '0;
        case (op_i)
            dmas_pkg::DMAS_OP_ADD, dmas_pkg::DMAS_OP_ADC,
            dmas_pkg::DMAS_OP_SUB, dmas_pkg::DMAS_OP_SBC: begin
                out_o.res = sum[7:0];
                out_o.c = sum[8];
                out_o.ac = low[4];
                out_o.ov = c7 ^ sum[8];
                out_o.wc = 1'b1;
                out_o.wac = 1'b1;
                out_o.wov = 1'b1;
                out_o.wz = 1'b1;
            end
            dmas_pkg::DMAS_OP_DAA: begin
                out_o.res = daa[7:0];
                out_o.c = daa[8] | c_i;
                out_o.wc = 1'b1;
            end
            dmas_pkg::DMAS_OP_AND: begin
                out_o.res = a_i & b_i;
                out_o.wz = 1'b1;
            end
            dmas_pkg::DMAS_OP_OR: begin
                out_o.res = a_i | b_i;
                out_o.wz = 1'b1;
            end
            dmas_pkg::DMAS_OP_XOR: begin
                out_o.res = a_i ^ b_i;
                out_o.wz = 1'b1;
            end
            dmas_pkg::DMAS_OP_CPL: begin
                out_o.res = ~b_i;
                out_o.wz = 1'b1;
            end
            dmas_pkg::DMAS_OP_RL: out_o.res = {b_i[6:0], b_i[7]};
            dmas_pkg::DMAS_OP_RR: out_o.res = {b_i[0], b_i[7:1]};
            dmas_pkg::DMAS_OP_RLC: begin
                out_o.res = {b_i[6:0], c_i};
                out_o.c = b_i[7];
                out_o.wc = 1'b1;
            end
            dmas_pkg::DMAS_OP_RRC: begin
                out_o.res = {c_i, b_i[7:1]};
                out_o.c = b_i[0];
                out_o.wc = 1'b1;
            end
            dmas_pkg::DMAS_OP_INC, dmas_pkg::DMAS_OP_DEC: begin
                out_o.res = sum[7:0];
                out_o.wz = 1'b1;
            end
            default: out_o.res = b_i;
        endcase
        out_o.z = (out_o.res == 8'h00);
    end
endmodule

// ---- src/dmas_core.sv ----
`timescale 1ns/1ps
module dmas_core #(
    parameter int BANK_BITS = dmas_pkg::BANK_BITS, // 6 largest member, 5 others
    parameter int BANK_COUNT = dmas_pkg::BANK_COUNT // number of RAM banks
) (
    input wire logic core_clk_i, // instruction clock
    input wire logic rst_b_i, // power-up reset, active low
    input wire logic op_valid_i, // execute one operation this cycle
    input wire dmas_pkg::dmas_op_e op_i, // operation code
    input wire logic [7:0] addr_i, // data memory operand address
    input wire logic use_imm_i, // take operand from imm_i
    input wire logic [7:0] imm_i, // immediate operand
    input wire dmas_pkg::dmas_dst_e dst_i, // result destination
    input wire logic halt_i, // halt instruction executed
    input wire logic wdt_clear_i, // watchdog clear instruction executed
    input wire logic wdt_timeout_i, // watchdog timeout event
    output logic [7:0] working_o, // working register
    output logic [7:0] status_o, // status register
    output logic [7:0] rd_data_o, // operand read last operation
    output logic skip_o // result was zero, for skip tests
);
    localparam int AW = BANK_BITS + 8;

    logic [7:0] working_register;
    logic [7:0] pointer_zero_reg;
    logic [7:0] pointer_one_reg;
    logic [BANK_BITS-1:0] ram_bank_select_reg;
    logic [5:0] status_reg;
    logic [7:0] rd_data_reg;
    logic skip_reg;
    logic [7:0] ram_mem [0:(1 << AW)-1];

    logic via_zero;
    logic via_one;
    logic indirect;
    logic [7:0] eff_addr;
    logic [BANK_BITS-1:0] eff_bank;
    logic port_loop;
    logic is_ram;
    logic bank_ok;
    logic [AW-1:0] ram_index;
    logic [7:0] special_rd;
    logic [7:0] mem_rd;
    logic [7:0] operand;
    logic [7:0] status_rd;
    dmas_pkg::dmas_alu_s alu;
    logic mem_we;
    logic work_we;
    logic stat_we;
    logic [5:0] status_next;

    assign via_zero = (addr_i == dmas_pkg::ADDR_PORT_ZERO);
    assign via_one = (addr_i == dmas_pkg::ADDR_PORT_ONE);
    assign indirect = via_zero | via_one;
    assign eff_addr = via_zero ? pointer_zero_reg : (via_one ? pointer_one_reg : addr_i);
    // register area is common to all banks; direct access is bank 0
    assign eff_bank = (via_one && eff_addr >= dmas_pkg::ADDR_RAM_BASE) ?
        ram_bank_select_reg : '0;
    assign port_loop = indirect && (eff_addr == dmas_pkg::ADDR_PORT_ZERO ||
        eff_addr == dmas_pkg::ADDR_PORT_ONE);
    assign is_ram = (eff_addr >= dmas_pkg::ADDR_RAM_BASE);
    assign bank_ok = (int'(eff_bank) < BANK_COUNT);
    assign ram_index = {eff_bank, eff_addr};
    assign status_rd = {2'b00, status_reg};

    always_comb begin
        case (eff_addr)
            dmas_pkg::ADDR_POINTER_ZERO: special_rd = pointer_zero_reg;
            dmas_pkg::ADDR_POINTER_ONE: special_rd = pointer_one_reg;
            dmas_pkg::ADDR_BANK_SELECT: special_rd = 8'(ram_bank_select_reg);
            dmas_pkg::ADDR_WORKING: special_rd = working_register;
            dmas_pkg::ADDR_STATUS: special_rd = status_rd;
            default: special_rd = dmas_pkg::RESET_BYTE;
        endcase
    end

    assign mem_rd = port_loop ? dmas_pkg::RESET_BYTE :
        (is_ram ? (bank_ok ? ram_mem[ram_index] : dmas_pkg::RESET_BYTE) : special_rd);
    assign operand = use_imm_i ? imm_i : mem_rd;

    dmas_alu u_alu (
        .op_i(op_i),
        .a_i(working_register),
        .b_i(operand),
        .c_i(status_reg[dmas_pkg::BIT_CARRY]),
        .ac_i(status_reg[dmas_pkg::BIT_HALF]),
        .out_o(alu)
    );

    // memory results only come from the working register or an alu op
    assign mem_we = op_valid_i && dst_i == dmas_pkg::DMAS_DST_MEM && !port_loop;
    assign work_we = op_valid_i && dst_i == dmas_pkg::DMAS_DST_WORK;
    assign stat_we = mem_we && !is_ram && eff_addr == dmas_pkg::ADDR_STATUS;

    always_comb begin
        status_next = status_reg;
        if (op_valid_i) begin
            if (alu.wc) status_next[dmas_pkg::BIT_CARRY] = alu.c;
            if (alu.wac) status_next[dmas_pkg::BIT_HALF] = alu.ac;
            if (alu.wz) status_next[dmas_pkg::BIT_ZERO] = alu.z;
            if (alu.wov) status_next[dmas_pkg::BIT_WRAP] = alu.ov;
        end
        if (stat_we) begin
            // halt and watchdog bits are not reachable by data writes
            status_next[3:0] = alu.res[3:0];
        end
        if (wdt_clear_i) begin
            status_next[dmas_pkg::BIT_HALT] = 1'b0;
            status_next[dmas_pkg::BIT_WDOG] = 1'b0;
        end
        if (halt_i) begin
            status_next[dmas_pkg::BIT_HALT] = 1'b1;
            status_next[dmas_pkg::BIT_WDOG] = 1'b0;
        end
        if (wdt_timeout_i) begin
            status_next[dmas_pkg::BIT_WDOG] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (mem_we && is_ram && bank_ok) begin
            ram_mem[ram_index] <= alu.res;
        end
    end

    // calls and interrupts have no port here: status is never stacked
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            working_register <= dmas_pkg::RESET_BYTE;
            pointer_zero_reg <= dmas_pkg::RESET_BYTE;
            pointer_one_reg <= dmas_pkg::RESET_BYTE;
            ram_bank_select_reg <= '0;
            status_reg <= '0;
            rd_data_reg <= dmas_pkg::RESET_BYTE;
            skip_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            if (work_we) working_register <= alu.res;
            if (mem_we && !is_ram) begin
                if (eff_addr == dmas_pkg::ADDR_POINTER_ZERO) pointer_zero_reg <= alu.res;
                if (eff_addr == dmas_pkg::ADDR_POINTER_ONE) pointer_one_reg <= alu.res;
                if (eff_addr == dmas_pkg::ADDR_BANK_SELECT) begin
                    ram_bank_select_reg <= alu.res[BANK_BITS-1:0];
                end
                if (eff_addr == dmas_pkg::ADDR_WORKING) working_register <= alu.res;
            end
            if (op_valid_i) begin
                rd_data_reg <= operand;
                skip_reg <= alu.z;
            end
        end
    end

    assign working_o = working_register;
    assign status_o = {2'b00, status_reg};
    assign rd_data_o = rd_data_reg;
    assign skip_o = skip_reg;
endmodule

// ---- tb/dmas_core_chk.sv ----
`timescale 1ns/1ps
module dmas_core_chk #(
    parameter int BANK_BITS = 6, // bank select width
    parameter int BANK_COUNT = 15 // ram banks
) (
    input wire logic core_clk_i, // clock
    input wire logic rst_b_i, // reset, active low
    input wire logic op_valid_i, // operation strobe
    input wire dmas_pkg::dmas_op_e op_i, // operation
    input wire logic [7:0] addr_i, // address
    input wire logic use_imm_i, // immediate select
    input wire logic [7:0] imm_i, // immediate
    input wire dmas_pkg::dmas_dst_e dst_i, // destination
    input wire logic halt_i, // halt
    input wire logic wdt_clear_i, // watchdog clear
    input wire logic wdt_timeout_i, // watchdog timeout
    input wire logic [7:0] working_o, // working register
    input wire logic [7:0] status_o, // status
    input wire logic [7:0] rd_data_o, // operand
    input wire logic skip_o // zero result
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    wire imm_work = op_valid_i && use_imm_i && dst_i == dmas_pkg::DMAS_DST_WORK;
    wire add_imm = imm_work && op_i == dmas_pkg::DMAS_OP_ADD;
    wire mov_imm = imm_work && op_i == dmas_pkg::DMAS_OP_MOV;
    wire no_evt = !halt_i && !wdt_clear_i;

    a_top_bits_zero: assert property (status_o[7:6] == 2'b00)
        else $error("status top bits set");
    a_timeout_sets_flag: assert property (wdt_timeout_i |=> status_o[5])
        else $error("timeout flag not set");
    a_halt_sets_flag: assert property (halt_i && !wdt_timeout_i |=> status_o[5:4] == 2'b01)
        else $error("halt flags wrong");
    a_clear_drops_flags: assert property (wdt_clear_i && !halt_i && !wdt_timeout_i |=> status_o[5:4] == 2'b00)
        else $error("clear flags wrong");
    a_wdog_flag_held: assert property (no_evt && !wdt_timeout_i |=> $stable(status_o[5]))
        else $error("watchdog flag moved");
    a_halt_flag_held: assert property (no_evt |=> $stable(status_o[4]))
        else $error("halt flag moved");
    a_add_result: assert property (add_imm |=> working_o == $past(working_o + imm_i))
        else $error("add result wrong");
    a_zero_skip: assert property (add_imm |=> skip_o == (working_o == 8'h00))
        else $error("skip flag wrong");
    a_mov_imm: assert property (mov_imm |=> working_o == $past(imm_i))
        else $error("immediate move wrong");
    a_idle_keeps_work: assert property (!op_valid_i |=> $stable(working_o))
        else $error("working register moved");
endmodule

bind dmas_core dmas_core_chk #(.BANK_BITS(BANK_BITS), .BANK_COUNT(BANK_COUNT)) u_chk (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .addr_i(addr_i), .use_imm_i(use_imm_i), .imm_i(imm_i), .dst_i(dst_i), .halt_i(halt_i),
    .wdt_clear_i(wdt_clear_i), .wdt_timeout_i(wdt_timeout_i), .working_o(working_o),
    .status_o(status_o), .rd_data_o(rd_data_o), .skip_o(skip_o));

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic core_clk_i, rst_b_i, op_valid_i, use_imm_i, halt_i, wdt_clear_i, wdt_timeout_i;
    logic [7:0] addr_i, imm_i, working_o, status_o, rd_data_o;
    logic skip_o;
    dmas_pkg::dmas_op_e op_i;
    dmas_pkg::dmas_dst_e dst_i;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    // flags nibble is {wrap, zero, half, carry}; msk picks the flags the op updates
    typedef struct packed {
        dmas_pkg::dmas_op_e op;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] res;
        logic [3:0] flg;
        logic [3:0] msk;
    } dmas_row_s;
    dmas_row_s rows [18];

    dmas_core DUT (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .op_valid_i(op_valid_i),
        .op_i(op_i), .addr_i(addr_i), .use_imm_i(use_imm_i), .imm_i(imm_i), .dst_i(dst_i),
        .halt_i(halt_i), .wdt_clear_i(wdt_clear_i), .wdt_timeout_i(wdt_timeout_i),
        .working_o(working_o), .status_o(status_o), .rd_data_o(rd_data_o), .skip_o(skip_o));

    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    task automatic results;
        $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            $display("[ERR] %0t run too long", $time);
            results();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic op(input dmas_pkg::dmas_op_e o, input logic [7:0] a, input logic im,
                      input logic [7:0] d, input dmas_pkg::dmas_dst_e t);
        op_valid_i = 1'b1;
        op_i = o;
        addr_i = a;
        use_imm_i = im;
        imm_i = d;
        dst_i = t;
        @(posedge core_clk_i);
        #2;
    endtask

    task automatic mov(input logic [7:0] a, input logic [7:0] d);
        op(dmas_pkg::DMAS_OP_MOV, a, 1'b1, d, dmas_pkg::DMAS_DST_MEM);
    endtask

    task automatic rd(input logic [7:0] a);
        op(dmas_pkg::DMAS_OP_MOV, a, 1'b0, 8'h00, dmas_pkg::DMAS_DST_WORK);
    endtask

    task automatic pulse(input logic h, input logic c, input logic t);
        op_valid_i = 1'b0;
        halt_i = h;
        wdt_clear_i = c;
        wdt_timeout_i = t;
        @(posedge core_clk_i);
        #2;
        halt_i = 1'b0;
        wdt_clear_i = 1'b0;
        wdt_timeout_i = 1'b0;
        // idle edge so a following pulse never re-drives a flag in this time step
        @(posedge core_clk_i);
        #2;
    endtask

    initial begin
        rows = '{
            '{dmas_pkg::DMAS_OP_ADD, 8'h0f, 8'h01, 8'h10, 4'h2, 4'hf},
            '{dmas_pkg::DMAS_OP_ADD, 8'h7f, 8'h01, 8'h80, 4'ha, 4'hf},
            '{dmas_pkg::DMAS_OP_DAA, 8'h1a, 8'h1a, 8'h20, 4'h0, 4'h1},
            '{dmas_pkg::DMAS_OP_ADD, 8'hff, 8'h01, 8'h00, 4'h7, 4'hf},
            '{dmas_pkg::DMAS_OP_ADC, 8'h10, 8'h20, 8'h31, 4'h0, 4'hf},
            '{dmas_pkg::DMAS_OP_RLC, 8'h80, 8'h80, 8'h00, 4'h1, 4'h1},
            '{dmas_pkg::DMAS_OP_RRC, 8'h01, 8'h01, 8'h80, 4'h1, 4'h1},
            '{dmas_pkg::DMAS_OP_SUB, 8'h05, 8'h05, 8'h00, 4'h7, 4'hf},
            '{dmas_pkg::DMAS_OP_SBC, 8'h33, 8'h33, 8'h00, 4'h7, 4'hf},
            '{dmas_pkg::DMAS_OP_AND, 8'hf0, 8'h0f, 8'h00, 4'h4, 4'h4},
            '{dmas_pkg::DMAS_OP_OR, 8'hf0, 8'h0f, 8'hff, 4'h0, 4'h4},
            '{dmas_pkg::DMAS_OP_XOR, 8'h5a, 8'h5a, 8'h00, 4'h4, 4'h4},
            '{dmas_pkg::DMAS_OP_CPL, 8'hff, 8'hff, 8'h00, 4'h4, 4'h4},
            '{dmas_pkg::DMAS_OP_RL, 8'h81, 8'h81, 8'h03, 4'h0, 4'h0},
            '{dmas_pkg::DMAS_OP_RR, 8'h81, 8'h81, 8'hc0, 4'h0, 4'h0},
            '{dmas_pkg::DMAS_OP_INC, 8'hff, 8'hff, 8'h00, 4'h4, 4'h4},
            '{dmas_pkg::DMAS_OP_DEC, 8'h01, 8'h01, 8'h00, 4'h4, 4'h4},
            '{dmas_pkg::DMAS_OP_MOV, 8'h5a, 8'h5a, 8'h5a, 4'h0, 4'h0}};
        rst_b_i = 1'b0;
        op_valid_i = 1'b0;
        op_i = dmas_pkg::DMAS_OP_ADD;
        addr_i = 8'h00;
        use_imm_i = 1'b0;
        imm_i = 8'h00;
        dst_i = dmas_pkg::DMAS_DST_NONE;
        halt_i = 1'b0;
        wdt_clear_i = 1'b0;
        wdt_timeout_i = 1'b0;
        repeat (12) @(posedge core_clk_i);
        #2;
        rst_b_i = 1'b1;
        chk8(status_o, 8'h00);
        foreach (rows[i]) begin
            op(dmas_pkg::DMAS_OP_MOV, 8'h00, 1'b1, rows[i].a, dmas_pkg::DMAS_DST_WORK);
            op(rows[i].op, 8'h00, 1'b1, rows[i].b, dmas_pkg::DMAS_DST_WORK);
            chk8(working_o, rows[i].res);
            chk8({4'h0, status_o[3:0] & rows[i].msk}, {4'h0, rows[i].flg});
            chk8({7'h00, skip_o}, {7'h00, rows[i].res == 8'h00});
        end
        // pointer_one in bank 1, direct access stays in bank 0
        mov(8'h04, 8'h01);
        mov(8'h03, 8'h50);
        mov(8'h02, 8'ha5);
        mov(8'h50, 8'h3c);
        rd(8'h02);
        chk8(working_o, 8'ha5);
        chk8(rd_data_o, 8'ha5);
        mov(8'h01, 8'h50);
        rd(8'h00);
        chk8(working_o, 8'h3c);
        mov(8'h03, 8'h05);
        mov(8'h02, 8'h77);
        chk8(working_o, 8'h77);
        mov(8'h01, 8'h02);
        rd(8'h00);
        chk8(working_o, 8'h00);
        mov(8'h04, 8'h0e);
        mov(8'h03, 8'hff);
        mov(8'h02, 8'h4b);
        rd(8'h02);
        chk8(working_o, 8'h4b);
        // bank select keeps only its six bits; bank 3fh has no RAM behind it
        mov(8'h04, 8'hff);
        rd(8'h04);
        chk8(working_o, 8'h3f);
        rd(8'h02);
        chk8(working_o, 8'h00);
        // software saves status in RAM around a flag-changing handler
        mov(8'h0a, 8'h05);
        rd(8'h0a);
        op(dmas_pkg::DMAS_OP_OR, 8'h41, 1'b1, 8'h00, dmas_pkg::DMAS_DST_MEM);
        op(dmas_pkg::DMAS_OP_ADD, 8'h00, 1'b1, 8'hfb, dmas_pkg::DMAS_DST_WORK);
        chk8(status_o, 8'h07);
        rd(8'h41);
        op(dmas_pkg::DMAS_OP_OR, 8'h0a, 1'b1, 8'h00, dmas_pkg::DMAS_DST_MEM);
        chk8(status_o, 8'h05);
        pulse(1'b1, 1'b0, 1'b0);
        chk8(status_o & 8'h30, 8'h10);
        pulse(1'b0, 1'b0, 1'b1);
        chk8(status_o & 8'h30, 8'h30);
        mov(8'h0a, 8'hff);
        chk8(status_o, 8'h3f);
        mov(8'h0a, 8'h00);
        chk8(status_o, 8'h30);
        pulse(1'b1, 1'b0, 1'b0);
        chk8(status_o & 8'h30, 8'h10);
        pulse(1'b0, 1'b1, 1'b0);
        chk8(status_o, 8'h00);
        pulse(1'b0, 1'b0, 1'b1);
        rst_b_i = 1'b0;
        @(posedge core_clk_i);
        #2;
        chk8(status_o, 8'h00);
        rst_b_i = 1'b1;
        results();
    end
endmodule
